/* File: rtl/vdmc_pkg.sv */
// shared constants and types for the video dac mode control block
package vdmc_pkg;
   localparam int          PIN_W        = 35;
   localparam int          ADDR_W       = 12;
   localparam logic [9:0]  CODE_ZERO    = 10'h000;
   localparam logic [9:0]  CODE_RED_BLK = 10'h040;
   localparam logic [9:0]  CODE_MID     = 10'h200;
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
   localparam int          CTRL_SAMP_EN = 0;
   localparam int          STB_VIDEO    = 0;
   localparam int          STB_BLANK    = 1;
   localparam int          STB_SYNC     = 2;
   localparam int          STB_SYNC_POS = 3;
   localparam int          STB_FMT_LO   = 4;
   localparam int          STB_FMT_HI   = 5;
   localparam int          STB_REDUCED  = 6;
   localparam int          STB_ALL_CH   = 7;
   localparam int          STB_PEND     = 8;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_WAIT = 2'b10
   } vdmc_samp_t;
endpackage

/* File: rtl/vdmc_pin_sync.sv */
// two-flop synchroniser for the control and data pins
`timescale 1ns/100ps
`default_nettype none
module vdmc_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins and their synchronised copies
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // first stage feeds only the second stage
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pin_sync = sync_q;
endmodule
`default_nettype wire

/* File: rtl/vdmc_top.sv */
// mode decode, config sampling and blank/sync control of the video dac
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module vdmc_top
   import vdmc_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // control pins from the timing source
   input  wire logic        sync_n,
   input  wire logic        blank_n,
   input  wire logic        pulse_select,
   input  wire logic        config_pin_a,
   input  wire logic        config_pin_b,
   // pixel data
   input  wire logic [9:0]  pix_g,
   input  wire logic [9:0]  pix_b,
   input  wire logic [9:0]  pix_r,
   // dac codes
   output logic      [9:0]  green_luma_output,
   output logic      [9:0]  blue_pb_output,
   output logic      [9:0]  red_pr_output,
   // analog control
   output logic             video_mode,
   output logic             dc_bias_en,
   output logic             blank_active,
   output logic             sync_green,
   output logic             sync_rb,
   output logic             sync_positive,
   // active configuration
   output logic             format_select_hi,
   output logic             format_select_lo,
   output logic             reduced_range_select,
   output logic             all_channel_pulse_select,
   // axi4-lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   function automatic logic [9:0] blank_code(input logic chroma,
                                             input logic reduced);
      if (chroma)
         return CODE_MID;
      return reduced ? CODE_RED_BLK : CODE_ZERO;
   endfunction

   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic             sync_s, blank_s, pulse_s, cfg_a_s, cfg_b_s;
   logic             sync_req_s, blank_req_s;
   logic [9:0]       pg_s, pb_s, pr_s;

   // sync and blank enter inverted so cleared flops read idle, no false edge
   assign pins_raw = {~sync_n, ~blank_n, pulse_select, config_pin_a,
                      config_pin_b, pix_g, pix_b, pix_r};

   vdmc_pin_sync #(.W(PIN_W)) u_pins (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_in   (pins_raw),
      .pin_sync (pins_s)
   );
   assign {sync_req_s, blank_req_s, pulse_s, cfg_a_s, cfg_b_s,
           pg_s, pb_s, pr_s} = pins_s;
   assign sync_s  = !sync_req_s;
   assign blank_s = !blank_req_s;

   // control register
   logic [31:0] ctrl_q, ctrl_d;
   logic        samp_en;
   assign samp_en = ctrl_q[CTRL_SAMP_EN];

   // mode decode
   logic generic, det, sample_now;
   logic sync_prev_q, sync_prev_d;
   assign generic = sync_s & pulse_s;
   assign det     = sync_s ^ sync_prev_q;

   // config sampler
   vdmc_samp_t samp_q, samp_d;
   logic fmt_hi_q, fmt_hi_d, fmt_lo_q, fmt_lo_d;
   logic red_q, red_d, all_q, all_d;

   assign sample_now = (samp_q == S_WAIT) && !det && !generic && samp_en;

   always_comb begin
      samp_d      = samp_q;
      sync_prev_d = sync_s;
      fmt_hi_d    = fmt_hi_q;
      fmt_lo_d    = fmt_lo_q;
      red_d       = red_q;
      all_d       = all_q;
      unique case (samp_q)
         S_IDLE: begin
            if (det)
               samp_d = S_WAIT;
         end
         S_WAIT: begin
            if (!det)
               samp_d = S_IDLE;
         end
         default: samp_d = S_IDLE;
      endcase
      if (sample_now) begin
         if (sync_s) begin
            fmt_hi_d = cfg_a_s;
            fmt_lo_d = cfg_b_s;
         end else begin
            red_d = cfg_a_s;
            all_d = cfg_b_s;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_q      <= S_IDLE;
         sync_prev_q <= 1'b1;
         fmt_hi_q    <= 1'b0;
         fmt_lo_q    <= 1'b0;
         red_q       <= 1'b0;
         all_q       <= 1'b0;
      end else begin
         samp_q      <= samp_d;
         sync_prev_q <= sync_prev_d;
         fmt_hi_q    <= fmt_hi_d;
         fmt_lo_q    <= fmt_lo_d;
         red_q       <= red_d;
         all_q       <= all_d;
      end
   end

   // effective configuration
   logic fmt_hi_e, fmt_lo_e, red_e, all_e, reduced, ycc;
   logic sync_act, blank_act;
   assign fmt_hi_e = generic ? cfg_a_s : fmt_hi_q;
   assign fmt_lo_e = generic ? cfg_b_s : fmt_lo_q;
   assign red_e    = !generic && red_q;
   assign all_e    = !generic && all_q;
   // select sense flips with the 4:2:2 formats
   assign reduced  = !generic && (red_q ^ fmt_hi_q);
   assign ycc      = fmt_hi_e | fmt_lo_e;
   assign sync_act = !sync_s;
   assign blank_act = sync_s && !blank_s;

   // output stage
   logic [9:0] g_q, g_d, b_q, b_d, r_q, r_d;
   logic video_q, video_d, bias_q, bias_d, blank_q, blank_d;
   logic syng_q, syng_d, synrb_q, synrb_d, synpos_q, synpos_d;
   logic ohi_q, ohi_d, olo_q, olo_d, ored_q, ored_d, oall_q, oall_d;

   always_comb begin
      video_d  = !generic;
      bias_d   = !generic;
      blank_d  = blank_act;
      syng_d   = sync_act;
      synrb_d  = sync_act && all_e;
      synpos_d = sync_act && pulse_s;
      ohi_d    = fmt_hi_e;
      olo_d    = fmt_lo_e;
      ored_d   = red_e;
      oall_d   = all_e;
      if (sync_act || blank_act) begin
         g_d = blank_code(1'b0, reduced);
         b_d = blank_code(ycc, reduced);
         r_d = blank_code(ycc, reduced);
      end else begin
         g_d = pg_s;
         b_d = pb_s;
         r_d = pr_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         g_q      <= CODE_ZERO;
         b_q      <= CODE_ZERO;
         r_q      <= CODE_ZERO;
         video_q  <= 1'b0;
         bias_q   <= 1'b0;
         blank_q  <= 1'b0;
         syng_q   <= 1'b0;
         synrb_q  <= 1'b0;
         synpos_q <= 1'b0;
         ohi_q    <= 1'b0;
         olo_q    <= 1'b0;
         ored_q   <= 1'b0;
         oall_q   <= 1'b0;
      end else begin
         g_q      <= g_d;
         b_q      <= b_d;
         r_q      <= r_d;
         video_q  <= video_d;
         bias_q   <= bias_d;
         blank_q  <= blank_d;
         syng_q   <= syng_d;
         synrb_q  <= synrb_d;
         synpos_q <= synpos_d;
         ohi_q    <= ohi_d;
         olo_q    <= olo_d;
         ored_q   <= ored_d;
         oall_q   <= oall_d;
      end
   end

   assign green_luma_output        = g_q;
   assign blue_pb_output           = b_q;
   assign red_pr_output            = r_q;
   assign video_mode               = video_q;
   assign dc_bias_en               = bias_q;
   assign blank_active             = blank_q;
   assign sync_green               = syng_q;
   assign sync_rb                  = synrb_q;
   assign sync_positive            = synpos_q;
   assign format_select_hi         = ohi_q;
   assign format_select_lo         = olo_q;
   assign reduced_range_select     = ored_q;
   assign all_channel_pulse_select = oall_q;

   // axi4-lite slave; one write and one read in flight
   logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] status;

   assign s_axi_awready = !awh_q && !bv_q;
   assign s_axi_wready  = !wh_q && !bv_q;
   assign s_axi_arready = !rv_q;

   always_comb begin
      status               = '0;
      status[STB_VIDEO]    = video_q;
      status[STB_BLANK]    = blank_q;
      status[STB_SYNC]     = syng_q;
      status[STB_SYNC_POS] = synpos_q;
      status[STB_FMT_LO]   = olo_q;
      status[STB_FMT_HI]   = ohi_q;
      status[STB_REDUCED]  = ored_q;
      status[STB_ALL_CH]   = oall_q;
      status[STB_PEND]     = (samp_q == S_WAIT);
   end

   always_comb begin
      awh_d  = awh_q;
      wh_d   = wh_q;
      awa_d  = awa_q;
      wd_d   = wd_q;
      ws_d   = ws_q;
      bv_d   = bv_q;
      br_d   = br_q;
      rv_d   = rv_q;
      rr_d   = rr_q;
      rd_d   = rd_q;
      ctrl_d = ctrl_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awh_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (awh_q && wh_q && !bv_q) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = RESP_OKAY;
         if (awa_q[11:2] == ADDR_CTRL[11:2]) begin
            for (int i = 0; i < 4; i++) begin
               if (ws_q[i])
                  ctrl_d[i*8 +: 8] = wd_q[i*8 +: 8];
            end
         end else if (awa_q[11:2] != ADDR_STATUS[11:2]) begin
            br_d = RESP_SLVERR;
         end
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rd_d = '0;
         if (s_axi_araddr[11:2] == ADDR_CTRL[11:2])
            rd_d = ctrl_q;
         else if (s_axi_araddr[11:2] == ADDR_STATUS[11:2])
            rd_d = status;
         else
            rr_d = RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awh_q  <= 1'b0;
         wh_q   <= 1'b0;
         awa_q  <= '0;
         wd_q   <= '0;
         ws_q   <= '0;
         bv_q   <= 1'b0;
         br_q   <= RESP_OKAY;
         rv_q   <= 1'b0;
         rr_q   <= RESP_OKAY;
         rd_q   <= '0;
         ctrl_q <= CTRL_RST;
      end else begin
         awh_q  <= awh_d;
         wh_q   <= wh_d;
         awa_q  <= awa_d;
         wd_q   <= wd_d;
         ws_q   <= ws_d;
         bv_q   <= bv_d;
         br_q   <= br_d;
         rv_q   <= rv_d;
         rr_q   <= rr_d;
         rd_q   <= rd_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp  = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rresp  = rr_q;
   assign s_axi_rdata  = rd_q;

   // checks
   sequence s_fall_wait;
      (det && !sync_s) ##1 (!det && !generic && samp_en);
   endsequence
   sequence s_rise_wait;
      (det && sync_s) ##1 (!det && !generic && samp_en);
   endsequence

   a_generic_pass: assert property (generic && blank_s |=>
      !video_mode && !blank_active && green_luma_output == $past(pg_s))
      else $error("generic pass-through wrong");
   a_generic_blank: assert property (generic && !blank_s |=>
      blank_active && !dc_bias_en && green_luma_output == CODE_ZERO)
      else $error("generic blanking wrong");
   a_video_pass: assert property (sync_s && blank_s && !pulse_s |=>
      video_mode && !blank_active && red_pr_output == $past(pr_s))
      else $error("video pass-through wrong");
   a_video_blank: assert property (sync_s && !blank_s && !pulse_s
      |=> blank_active && dc_bias_en)
      else $error("video blanking wrong");
   a_neg_sync: assert property (!sync_s && !pulse_s |=>
      sync_green && !sync_positive && video_mode)
      else $error("negative sync wrong");
   a_pos_sync: assert property (!sync_s && pulse_s |=>
      sync_green && sync_positive && video_mode)
      else $error("positive sync wrong");
   a_sync_priority: assert property (!sync_s && !blank_s |=>
      !blank_active)
      else $error("blank beat sync");
   a_fall_load: assert property (s_fall_wait |=>
      red_q == $past(cfg_a_s) && all_q == $past(cfg_b_s))
      else $error("falling edge load wrong");
   a_rise_load: assert property (s_rise_wait |=>
      fmt_hi_q == $past(cfg_a_s) && fmt_lo_q == $past(cfg_b_s))
      else $error("rising edge load wrong");
   a_hold_cfg: assert property (!sample_now |=>
      $stable({fmt_hi_q, fmt_lo_q, red_q, all_q}))
      else $error("select changed without sample");
   a_restart_count: assert property (det ##1 det |=>
      samp_q == S_WAIT && $stable({fmt_hi_q, fmt_lo_q, red_q, all_q}))
      else $error("count not restarted");
   a_generic_fmt: assert property (generic |=>
      format_select_hi == $past(cfg_a_s) &&
      format_select_lo == $past(cfg_b_s))
      else $error("generic format not continuous");
   a_generic_off: assert property (generic |=> !sync_green &&
      !reduced_range_select && !all_channel_pulse_select)
      else $error("generic kept video controls");
   a_sync_channels: assert property (sync_green |->
      sync_rb == all_channel_pulse_select)
      else $error("sync channel choice wrong");
   a_chroma_mid: assert property (blank_active &&
      (format_select_hi || format_select_lo) |-> blue_pb_output == CODE_MID)
      else $error("chroma blank not mid code");
endmodule
`default_nettype wire

/* File: verification/vdmc_timing_src.sv */
// timing source model that drives the dac control pins
`timescale 1ns/100ps
`default_nettype none
module vdmc_timing_src (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // requests from the bench
   input  wire logic want_sync,
   input  wire logic want_blank,
   input  wire logic want_pos,
   input  wire logic want_gen,
   input  wire logic want_a,
   input  wire logic want_b,
   // control pins
   output logic      sync_n,
   output logic      blank_n,
   output logic      pulse_select,
   output logic      config_pin_a,
   output logic      config_pin_b
);
   // pins launched on the clock edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_n       <= 1'b1;
         blank_n      <= 1'b1;
         pulse_select <= 1'b0;
         config_pin_a <= 1'b0;
         config_pin_b <= 1'b0;
      end else begin
         sync_n       <= ~want_sync;
         blank_n      <= ~want_blank;
         pulse_select <= want_sync ? want_pos : want_gen;
         config_pin_a <= want_a;
         config_pin_b <= want_b;
      end
   end
endmodule
`default_nettype wire

/* File: verification/vdmc_tb.sv */
// self-checking bench for the video dac mode control block
`timescale 1ns/100ps
`default_nettype none
module vdmc_tb
   import vdmc_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        want_sync = 1'b0, want_blank = 1'b0, want_pos = 1'b0;
   logic        want_gen = 1'b0, want_a = 1'b0, want_b = 1'b0;
   logic        sync_n, blank_n, pulse_select, config_pin_a, config_pin_b;
   logic [9:0]  pix_g = 10'h155, pix_b = 10'h2aa, pix_r = 10'h0f0;
   logic [9:0]  o_g, o_b, o_r;
   logic        video_mode, dc_bias_en, blank_active, sync_green, sync_rb;
   logic        sync_positive, f_hi, f_lo, red, allc;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   int          err_count = 0, check_count = 0, cyc = 0;

   always #5 aclk = ~aclk;

   vdmc_timing_src i_vdmc_timing_src (
      .aclk, .aresetn, .want_sync, .want_blank, .want_pos, .want_gen,
      .want_a, .want_b, .sync_n, .blank_n, .pulse_select, .config_pin_a,
      .config_pin_b);

   vdmc_top i_vdmc_top (
      .aclk, .aresetn, .sync_n, .blank_n, .pulse_select, .config_pin_a,
      .config_pin_b, .pix_g, .pix_b, .pix_r, .green_luma_output(o_g),
      .blue_pb_output(o_b), .red_pr_output(o_r), .video_mode, .dc_bias_en,
      .blank_active, .sync_green, .sync_rb, .sync_positive,
      .format_select_hi(f_hi), .format_select_lo(f_lo),
      .reduced_range_select(red), .all_channel_pulse_select(allc),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request order {sync, blank, pulse, generic, pin a, pin b}
   task automatic pins(input logic [5:0] v, input int n);
      @(posedge aclk);
      {want_sync, want_blank, want_pos, want_gen, want_a, want_b} <= v;
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   // handshakes judged at the falling edge, acted on at the next rise
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         output logic [1:0] resp);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // no local limit: a stuck wait is ended by the hang guard
      while (!tb) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] resp);
      logic ta, tr;
      tr = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADDR_CTRL, d, r);
      chk("ctrl_reset", d, CTRL_RST);
      chk("ctrl_resp", r, RESP_OKAY);
      axi_rd(ADDR_STATUS, d, r);
      chk("status", d, 32'h0000_0001);
      axi_wr(12'h008, 32'hffff_ffff, r);
      chk("bad_wr_resp", r, RESP_SLVERR);
      axi_rd(12'h008, d, r);
      chk("bad_rd_data", d, 32'h0);
      chk("bad_rd_resp", r, RESP_SLVERR);
      axi_wr(ADDR_STATUS, 32'h0, r);
      chk("ro_wr_resp", r, RESP_OKAY);
      // sampling switched off, so a falling sync must load nothing
      axi_wr(ADDR_CTRL, 32'h0, r);
      pins(6'b100011, 10);
      chk("reduced_off", red, 1'b0);
      axi_wr(ADDR_CTRL, CTRL_RST, r);
      axi_rd(ADDR_CTRL, d, r);
      chk("ctrl_back", d, CTRL_RST);
      $display("test regs done");
   endtask

   task automatic t_modes();
      logic [5:0] rq [6] = '{6'b000100, 6'b010100, 6'b000000, 6'b010000,
                             6'b110000, 6'b101000};
      logic [4:0] ex [6] = '{5'b00000, 5'b01001, 5'b10000, 5'b11001,
                             5'b10101, 5'b10111};
      for (int i = 0; i < 6; i++) begin
         pins(rq[i], 6);
         chk("video_mode", video_mode, ex[i][4]);
         chk("dc_bias_en", dc_bias_en, ex[i][4]);
         chk("sync_green", sync_green, ex[i][2]);
         chk("sync_positive", sync_positive, ex[i][1]);
         if (!rq[i][5]) chk("blank_active", blank_active, ex[i][3]);
         chk("green_code", o_g, ex[i][0] ? 10'h000 : pix_g);
         chk("blue_code", o_b, ex[i][0] ? 10'h000 : pix_b);
         chk("red_code", o_r, ex[i][0] ? 10'h000 : pix_r);
      end
      $display("test modes done");
   endtask

   task automatic t_sample();
      pins(6'b000000, 10);
      pins(6'b100011, 10);
      chk("reduced", red, 1'b1);
      chk("all_ch", allc, 1'b1);
      chk("sync_rb", sync_rb, 1'b1);
      pins(6'b100000, 6);
      chk("reduced_hold", red, 1'b1);
      chk("all_ch_hold", allc, 1'b1);
      pins(6'b000001, 10);
      chk("fmt_hi", f_hi, 1'b0);
      chk("fmt_lo", f_lo, 1'b1);
      chk("reduced_keep", red, 1'b1);
      pins(6'b010001, 6);
      chk("blank_y", o_g, CODE_RED_BLK);
      chk("blank_pb", o_b, CODE_MID);
      chk("blank_pr", o_r, CODE_MID);
      pins(6'b100000, 10);
      chk("sync_green", sync_green, 1'b1);
      chk("sync_rb_off", sync_rb, 1'b0);
      pins(6'b010001, 10);
      chk("blank_y_full", o_g, CODE_ZERO);
      $display("test sample done");
   endtask

   task automatic t_restart();
      pins(6'b100011, 0);
      pins(6'b000011, 10);
      chk("fmt_hi", f_hi, 1'b1);
      chk("fmt_lo", f_lo, 1'b1);
      chk("reduced_kept", red, 1'b0);
      pins(6'b100011, 10);
      chk("reduced", red, 1'b1);
      $display("test restart done");
   endtask

   task automatic t_generic();
      pins(6'b000110, 6);
      chk("video_mode", video_mode, 1'b0);
      chk("fmt_hi", f_hi, 1'b1);
      chk("fmt_lo", f_lo, 1'b0);
      chk("reduced_off", red, 1'b0);
      chk("all_ch_off", allc, 1'b0);
      pins(6'b010101, 6);
      chk("fmt_lo", f_lo, 1'b1);
      chk("blank_active", blank_active, 1'b1);
      chk("blank_y", o_g, CODE_ZERO);
      chk("blank_pb", o_b, CODE_MID);
      chk("dc_bias", dc_bias_en, 1'b0);
      $display("test generic done");
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (12) @(posedge aclk);
      t_regs();
      t_modes();
      t_sample();
      t_restart();
      t_generic();
      complete_run();
   end
endmodule
`default_nettype wire
